// file: hdl/cpu_seq_regs.svh
// Purpose: constants for the instruction sequencer: opcodes, GRS map, vectors
// Assumes: 36-bit words, 18-bit storage addresses, 7-bit register stack address
// Notes:   opcode values other than the invalid-code vector are local encodings
`ifndef CPU_SEQ_REGS_SVH
`define CPU_SEQ_REGS_SVH

// instruction word fields: f[35:30] j[29:26] a[25:22] x[21:18] u[17:0]
`define OP_TZ         6'h04
`define OP_TNZ        6'h05
`define OP_TP         6'h06
`define OP_TN         6'h07
`define OP_SHC        6'h08
`define OP_SHL        6'h09
`define OP_SHA        6'h0A
`define OP_LSC        6'h0B
`define OP_JZ         6'h10
`define OP_JNZ        6'h11
`define OP_JP         6'h12
`define OP_JN         6'h13
`define OP_JGD        6'h14
`define OP_AND        6'h18
`define OP_OR         6'h19
`define OP_XOR        6'h1A
`define OP_EX         6'h20
`define OP_ER         6'h21
`define OP_TS         6'h22
`define OP_NOP        6'h23
`define OP_LPSR       6'h24
`define OP_CHAR       6'h28
`define IO_GROUP      3'h6

`define J_DOUBLE      0
`define J_LEFT        1
`define SHIFT_MAX     7'h48
`define CHAR_X_MAX    4'hD

`define GRS_A_BASE    7'h0C
`define SAVE_BASE     7'h20
`define PSW_GUARD_BIT 2
`define TS_FLAG_MASK  36'h040000000

`define RESET_PC      18'h00000
`define VEC_INVALID   18'h000A1
`define VEC_GUARD     18'h000A2
`define VEC_ER        18'h000A3
`define VEC_TS        18'h000A4

`endif

// file: hdl/cpu_seq_pkg.sv
// Purpose: types shared by the sequencer and its shift unit
// Assumes: nothing
// Notes:   state codes are left to the tool; shift-kind codes follow op[1:0] of SHC, SHL, SHA
package cpu_seq_pkg;
  typedef enum logic [3:0] {
    ST_FETCH, ST_DECODE, ST_READ_A, ST_OPERAND, ST_EXEC,
    ST_NORM, ST_WRITE, ST_MEMWR, ST_TRAP
  } seq_state_t;
  typedef enum logic [1:0] {SK_CIRC, SK_LOGIC, SK_ALG} shift_kind_t;
  typedef logic [35:0] word_t;
endpackage

// file: hdl/grs_mem.sv
// Purpose: general register stack storage, one write and one registered read
// Assumes: a read of an address written in the same cycle returns old data
// Notes:   contents are not reset, software loads what it uses
`timescale 1ns/10ps
module grs_mem #(
  parameter int W  = 36,
  parameter int AW = 7
) (
  input  wire logic          core_clk_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in
);
  logic [W-1:0] mem_q [2**AW];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

// file: hdl/shift_unit.sv
// Purpose: circular, logical and algebraic shifter, single or double word
// Assumes: single word sits in data_in[71:36], low word passes unchanged
// Notes:   counts above 72 give whatever falls out, no defined result
`timescale 1ns/10ps
module shift_unit
  import cpu_seq_pkg::*;
(
  input  wire logic        [71:0] data_in,
  input  wire logic               double_in,
  input  wire logic               left_in,
  input  wire shift_kind_t        kind_in,
  input  wire logic        [6:0]  amount_in,
  output logic             [71:0] result_out
);
  logic [35:0]  s_in;
  logic [35:0]  s_out;
  logic [71:0]  d_out;
  logic [71:0]  s_rot;
  logic [143:0] d_rot;
  logic [6:0]   s_r;
  logic [6:0]   d_r;

  always_comb begin
    s_in  = data_in[71:36];
    s_r   = amount_in % 7'h24;
    d_r   = (amount_in >= 7'h48) ? 7'(amount_in - 7'h48) : amount_in;
    s_rot = left_in ? ({s_in, s_in} << s_r) : ({s_in, s_in} >> s_r);
    d_rot = left_in ? ({data_in, data_in} << d_r) : ({data_in, data_in} >> d_r);
    case (kind_in)
      SK_CIRC: begin
        s_out = left_in ? s_rot[71:36] : s_rot[35:0];
        d_out = left_in ? d_rot[143:72] : d_rot[71:0];
      end
      SK_ALG: begin
        if (left_in) begin
          s_out = s_in << amount_in;
          d_out = data_in << amount_in;
        end else begin
          // kept out of a ?: whose unsigned arm would turn >>> into a logical shift
          s_out = $signed(s_in) >>> amount_in;
          d_out = $signed(data_in) >>> amount_in;
        end
      end
      default: begin
        s_out = left_in ? (s_in << amount_in) : (s_in >> amount_in);
        d_out = left_in ? (data_in << amount_in) : (data_in >> amount_in);
      end
    endcase
    result_out = double_in ? d_out : {s_out, data_in[35:0]};
  end
endmodule

// file: hdl/cpu_instruction_sequencing.sv
// Purpose: command_arithmetic_unit sequencer for test, shift, jump, logic,
//          execute, trap, I/O and character instruction classes
// Assumes: storage answers with mem_ack_in on the same clock, any latency
// Notes:   one instruction at a time; no overlap, so no hazards between them
`timescale 1ns/10ps
`include "cpu_seq_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - test operand, skip next when condition holds
// - circular, logical, algebraic shifts, left or right
// - shifted result returns to source accumulator(s)
// - shift amount is u field bits 6..0
// - counts above 72 give undefined result
// - shift-and-count normalises storage operand, ignores count
// - rotate left until top two bits differ
// - rotation count goes to adjoining accumulator
// - conditional jump fetches next from operand address
// - jump-greater-decrement tests register at j,a address
// - AND/OR/XOR result lands in A plus one
// - execute runs remote instruction without jumping there
// - after remote instruction, continue past the execute
// - executive return raises an interrupt
// - test-and-set a field picks interrupt or skip
// - I/O in guard mode: suppressed, guard fault
// - invalid opcode interrupts to location octal 241
// - character ops use index registers X, X+1, X+2
// - count primary and extended storage references separately
// - interrupt saves four state words, leaves guard mode
module cpu_instruction_sequencing
  import cpu_seq_pkg::*;
#(
  parameter int CNT_W = 36
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  output logic                  mem_req_out,
  output logic                  mem_we_out,
  output logic                  mem_ext_out,
  output logic      [17:0]      mem_addr_out,
  output logic      [35:0]      mem_wdata_out,
  input  wire logic             mem_ack_in,
  input  wire logic [35:0]      mem_rdata_in,
  output logic                  io_req_out,
  output logic      [35:0]      io_cmd_out,
  output logic                  char_req_out,
  output logic      [11:0]      char_index_out,
  output logic                  guard_mode_out,
  output logic      [CNT_W-1:0] ref_prim_out,
  output logic      [CNT_W-1:0] ref_ext_out
);
  seq_state_t  state_q;
  logic [1:0]  step_q;
  logic [17:0] pc_q;
  logic        xeq_q;
  logic [17:0] xeq_addr_q;
  logic [35:0] instr_q;
  logic [71:0] acc_q;
  logic [71:0] res_q;
  logic [6:0]  cnt_q;
  logic [17:0] trap_vec_q;
  logic [6:0]  wr_base_q;
  logic [1:0]  wr_last_q;
  logic        wr_cnt_q;
  word_t       psw_q [4];

  logic [5:0]  op;
  logic [3:0]  fj;
  logic [3:0]  fa;
  logic [3:0]  fx;
  logic [17:0] fu;
  logic        dbl;
  logic        guard;
  logic [6:0]  a_addr;
  logic [6:0]  jgd_addr;
  logic [17:0] pc_seq;
  logic [17:0] pc_skip;
  logic        is_test;
  logic        is_shift;
  logic        is_lsc;
  logic        is_jcond;
  logic        is_jgd;
  logic        is_logic;
  logic        is_io;
  logic        known;
  logic        needs_a;
  logic        needs_opnd;
  logic        test_cond;
  logic        jump_cond;
  logic        ts_set;
  logic        norm_done;
  logic [35:0] logic_res;
  logic [71:0] shift_res;
  logic [6:0]  grs_ra;
  logic [35:0] grs_rd;
  logic        grs_we;
  logic [6:0]  grs_wa;
  logic [35:0] grs_wd;

  function automatic logic cond_f(input logic [1:0] sel, input logic [35:0] w);
    case (sel)
      2'h0:    cond_f = (w == 36'h000000000);
      2'h1:    cond_f = (w != 36'h000000000);
      2'h2:    cond_f = !w[35];
      default: cond_f = w[35];
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode
  assign op       = instr_q[35:30];
  assign fj       = instr_q[29:26];
  assign fa       = instr_q[25:22];
  assign fx       = instr_q[21:18];
  assign fu       = instr_q[17:0];
  assign dbl      = fj[`J_DOUBLE];
  assign guard    = psw_q[0][`PSW_GUARD_BIT];
  assign a_addr   = `GRS_A_BASE + {3'h0, fa};
  assign jgd_addr = {fj[2:0], fa};
  assign pc_seq   = pc_q + 18'h00001;
  assign pc_skip  = pc_q + 18'h00002;

  assign is_test  = (op[5:2] == 4'h1);
  assign is_shift = (op == `OP_SHC) || (op == `OP_SHL) || (op == `OP_SHA);
  assign is_lsc   = (op == `OP_LSC);
  assign is_jcond = (op[5:2] == 4'h4);
  assign is_jgd   = (op == `OP_JGD);
  assign is_logic = (op == `OP_AND) || (op == `OP_OR) || (op == `OP_XOR);
  assign is_io    = (op[5:3] == `IO_GROUP);
  assign known    = is_test || is_shift || is_lsc || is_jcond || is_jgd || is_logic
                 || is_io || (op == `OP_EX) || (op == `OP_ER) || (op == `OP_TS)
                 || (op == `OP_NOP) || (op == `OP_LPSR) || (op == `OP_CHAR);
  assign needs_a    = is_shift || is_jcond || is_jgd || is_logic;
  assign needs_opnd = is_test || is_logic || is_lsc || (op == `OP_TS) || (op == `OP_LPSR);

  assign test_cond = cond_f(op[1:0], res_q[71:36]);
  assign jump_cond = cond_f(op[1:0], acc_q[71:36]);
  assign ts_set    = |(res_q[71:36] & `TS_FLAG_MASK);
  // normalised once the top two bits of the high word differ
  assign norm_done = res_q[71] ^ res_q[70];

  always_comb begin
    case (op)
      `OP_AND: logic_res = acc_q[71:36] & res_q[71:36];
      `OP_OR:  logic_res = acc_q[71:36] | res_q[71:36];
      default: logic_res = acc_q[71:36] ^ res_q[71:36];
    endcase
  end

  // amount is u[6:0]; results for counts beyond 72 are not guaranteed
  shift_unit u_shift (
    .data_in    (acc_q),
    .double_in  (dbl),
    .left_in    (fj[`J_LEFT]),
    .kind_in    (shift_kind_t'(op[1:0])),
    .amount_in  (fu[6:0]),
    .result_out (shift_res)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register stack ports
  always_comb begin
    grs_ra = (state_q == ST_READ_A) ? 7'(a_addr + 7'h01) : (is_jgd ? jgd_addr : a_addr);
    grs_we = (state_q == ST_WRITE) || (state_q == ST_TRAP);
    if (state_q == ST_TRAP) begin
      grs_wa = `SAVE_BASE + {5'h00, step_q};
      grs_wd = psw_q[step_q];
    end else begin
      grs_wa = wr_base_q + {5'h00, step_q};
      if (wr_cnt_q && (step_q == wr_last_q)) begin
        grs_wd = {29'h00000000, cnt_q};
      end else begin
        grs_wd = (step_q == 2'h0) ? res_q[71:36] : res_q[35:0];
      end
    end
  end

  grs_mem #(.W(36), .AW(7)) u_grs (
    .core_clk_in (core_clk_in),
    .rd_addr_in  (grs_ra),
    .rd_data_out (grs_rd),
    .wr_en_in    (grs_we),
    .wr_addr_in  (grs_wa),
    .wr_data_in  (grs_wd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // storage port
  always_comb begin
    mem_req_out   = (state_q == ST_FETCH) || (state_q == ST_OPERAND) || (state_q == ST_MEMWR);
    mem_we_out    = (state_q == ST_MEMWR);
    mem_wdata_out = res_q[71:36] | `TS_FLAG_MASK;
    case (state_q)
      ST_FETCH:   mem_addr_out = xeq_q ? xeq_addr_q : pc_q;
      ST_OPERAND: mem_addr_out = fu + {16'h0000, step_q};
      default:    mem_addr_out = fu;
    endcase
    mem_ext_out = mem_addr_out[17];
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q    <= ST_FETCH;
      step_q     <= 2'h0;
      pc_q       <= `RESET_PC;
      xeq_q      <= 1'b0;
      xeq_addr_q <= 18'h00000;
      instr_q    <= 36'h000000000;
      acc_q      <= 72'h0;
      res_q      <= 72'h0;
      cnt_q      <= 7'h00;
      trap_vec_q <= 18'h00000;
      wr_base_q  <= 7'h00;
      wr_last_q  <= 2'h0;
      wr_cnt_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_FETCH: begin
          if (mem_ack_in) begin
            instr_q <= mem_rdata_in;
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          step_q <= 2'h0;
          if (!known) begin
            trap_vec_q <= `VEC_INVALID;
            state_q    <= ST_TRAP;
          end else if ((is_io || (op == `OP_LPSR)) && guard) begin
            trap_vec_q <= `VEC_GUARD;
            state_q    <= ST_TRAP;
          end else if (op == `OP_ER) begin
            trap_vec_q <= `VEC_ER;
            state_q    <= ST_TRAP;
          end else if (op == `OP_EX) begin
            xeq_q      <= 1'b1;
            xeq_addr_q <= fu;
            state_q    <= ST_FETCH;
          end else if (needs_a) begin
            state_q <= ST_READ_A;
          end else if (needs_opnd) begin
            state_q <= ST_OPERAND;
          end else begin
            pc_q    <= pc_seq;
            xeq_q   <= 1'b0;
            state_q <= ST_FETCH;
          end
        end
        ST_READ_A: begin
          if (step_q == 2'h0) begin
            acc_q[71:36] <= grs_rd;
            step_q       <= 2'h1;
          end else begin
            acc_q[35:0] <= grs_rd;
            step_q      <= 2'h0;
            state_q     <= needs_opnd ? ST_OPERAND : ST_EXEC;
          end
        end
        ST_OPERAND: begin
          if (mem_ack_in) begin
            if (step_q == 2'h0) begin
              res_q <= {mem_rdata_in, 36'h000000000};
            end else begin
              res_q[35:0] <= mem_rdata_in;
            end
            if (is_lsc && dbl && (step_q == 2'h0)) begin
              step_q <= 2'h1;
            end else begin
              step_q  <= 2'h0;
              cnt_q   <= 7'h00;
              state_q <= is_lsc ? ST_NORM : ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          xeq_q     <= 1'b0;
          wr_cnt_q  <= 1'b0;
          wr_last_q <= 2'h0;
          state_q   <= ST_FETCH;
          pc_q      <= pc_seq;
          if (is_test) begin
            pc_q <= test_cond ? pc_skip : pc_seq;
          end else if (is_shift) begin
            res_q     <= shift_res;
            wr_base_q <= a_addr;
            wr_last_q <= {1'b0, dbl};
            state_q   <= ST_WRITE;
          end else if (is_logic) begin
            res_q[71:36] <= logic_res;
            wr_base_q    <= 7'(a_addr + 7'h01);
            state_q      <= ST_WRITE;
          end else if (is_jcond) begin
            pc_q <= jump_cond ? fu : pc_seq;
          end else if (is_jgd) begin
            // test the old value, then store it back decremented
            pc_q         <= (!acc_q[71] && (|acc_q[71:36])) ? fu : pc_seq;
            res_q[71:36] <= acc_q[71:36] - 36'h000000001;
            wr_base_q    <= jgd_addr;
            state_q      <= ST_WRITE;
          end else if (op == `OP_TS) begin
            if (ts_set && (fa == 4'h0)) begin
              trap_vec_q <= `VEC_TS;
              state_q    <= ST_TRAP;
            end else if (ts_set) begin
              pc_q <= pc_skip;
            end else begin
              state_q <= ST_MEMWR;
            end
          end
        end
        ST_NORM: begin
          // all-zero or all-one words never split, so the count caps at 72
          if (norm_done || (cnt_q == `SHIFT_MAX)) begin
            wr_base_q <= a_addr;
            wr_last_q <= dbl ? 2'h2 : 2'h1;
            wr_cnt_q  <= 1'b1;
            pc_q      <= pc_seq;
            xeq_q     <= 1'b0;
            state_q   <= ST_WRITE;
          end else begin
            res_q <= dbl ? {res_q[70:0], res_q[71]}
                         : {res_q[70:36], res_q[71], res_q[35:0]};
            cnt_q <= cnt_q + 7'h01;
          end
        end
        ST_WRITE: begin
          if (step_q == wr_last_q) begin
            step_q  <= 2'h0;
            state_q <= ST_FETCH;
          end else begin
            step_q <= step_q + 2'h1;
          end
        end
        ST_MEMWR: begin
          if (mem_ack_in) begin
            state_q <= ST_FETCH;
          end
        end
        ST_TRAP: begin
          if (step_q == 2'h3) begin
            pc_q    <= trap_vec_q;
            xeq_q   <= 1'b0;
            step_q  <= 2'h0;
            state_q <= ST_FETCH;
          end else begin
            step_q <= step_q + 2'h1;
          end
        end
        default: state_q <= ST_FETCH;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // processor_state_word copies; guard drops only after all four are saved
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 4; i++) begin
        psw_q[i] <= 36'h000000000;
      end
    end else if ((state_q == ST_EXEC) && (op == `OP_LPSR)) begin
      psw_q[fj[1:0]] <= res_q[71:36];
    end else if ((state_q == ST_TRAP) && (step_q == 2'h3)) begin
      psw_q[0][`PSW_GUARD_BIT] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage reference counters
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ref_prim_out <= '0;
      ref_ext_out  <= '0;
    end else if (mem_req_out && mem_ack_in) begin
      if (mem_ext_out) begin
        ref_ext_out <= ref_ext_out + 1'b1;
      end else begin
        ref_prim_out <= ref_prim_out + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // io_access_unit command and character index outputs
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      io_req_out     <= 1'b0;
      io_cmd_out     <= 36'h000000000;
      char_req_out   <= 1'b0;
      char_index_out <= 12'h000;
    end else begin
      io_req_out   <= (state_q == ST_DECODE) && is_io && !guard;
      char_req_out <= (state_q == ST_DECODE) && (op == `OP_CHAR);
      if ((state_q == ST_DECODE) && is_io) begin
        io_cmd_out <= instr_q;
      end
      if ((state_q == ST_DECODE) && (op == `OP_CHAR)) begin
        // x above CHAR_X_MAX wraps; keeping it in range is software's job
        char_index_out <= {4'(fx + 4'h2), 4'(fx + 4'h1), fx};
      end
    end
  end

  assign guard_mode_out = guard;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_test_skip;
    (state_q == ST_EXEC) && is_test && test_cond |=> pc_q == 18'($past(pc_q) + 18'h2);
  endproperty
  a_test_skip: assert property (p_test_skip) else $error("skip not by two");

  property p_test_seq;
    (state_q == ST_EXEC) && is_test && !test_cond |=> pc_q == 18'($past(pc_q) + 18'h1);
  endproperty
  a_test_seq: assert property (p_test_seq) else $error("test fail not sequential");

  property p_jump;
    (state_q == ST_EXEC) && is_jcond && jump_cond |=> pc_q == $past(fu);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_execute;
    (state_q == ST_DECODE) && known && (op == `OP_EX) && !guard
      |=> (pc_q == $past(pc_q)) && mem_req_out && (mem_addr_out == $past(fu));
  endproperty
  a_execute: assert property (p_execute) else $error("execute moved control");

  property p_invalid;
    (state_q == ST_DECODE) && !known |=> (state_q == ST_TRAP) ##4 pc_q == `VEC_INVALID;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid op vector wrong");

  property p_guard_io;
    (state_q == ST_DECODE) && is_io && guard |=> !io_req_out && (state_q == ST_TRAP);
  endproperty
  a_guard_io: assert property (p_guard_io) else $error("io not suppressed");

  property p_trap_exit;
    (state_q == ST_TRAP) && (step_q == 2'h3) |-> grs_we && (grs_wa == 7'h23) ##1 !guard;
  endproperty
  a_trap_exit: assert property (p_trap_exit) else $error("state save or guard wrong");

  property p_ref;
    mem_req_out && mem_ack_in && !mem_ext_out
      |=> ref_prim_out == CNT_W'($past(ref_prim_out) + 1'b1) && $stable(ref_ext_out);
  endproperty
  a_ref: assert property (p_ref) else $error("primary counter missed");

  property p_norm_step;
    (state_q == ST_NORM) && !norm_done && (cnt_q != `SHIFT_MAX)
      |=> (state_q == ST_NORM) && (cnt_q == 7'($past(cnt_q) + 7'h01));
  endproperty
  a_norm_step: assert property (p_norm_step) else $error("normalise stopped early");

  property p_shift_wb;
    (state_q == ST_EXEC) && is_shift
      |=> grs_we && (grs_wa == $past(a_addr)) && (grs_wd == $past(shift_res[71:36]));
  endproperty
  a_shift_wb: assert property (p_shift_wb) else $error("shift writeback wrong");

  property p_logic_dest;
    (state_q == ST_EXEC) && is_logic |=> grs_we && (grs_wa == 7'($past(a_addr) + 7'h01));
  endproperty
  a_logic_dest: assert property (p_logic_dest) else $error("logic dest not A+1");
endmodule

// file: verification/storage_model.sv
// Purpose: primary and extended storage seen from the sequencer
// Assumes: 256 words, addresses fold onto bits 7..0, extended shares the array
// Notes:   ack after lat_in wait cycles; hold_in withholds every answer
`timescale 1ns/10ps
module storage_model (
  input  wire logic        core_clk_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [35:0] wdata_in,
  input  wire logic [1:0]  lat_in,
  input  wire logic        hold_in,
  output logic             ack_out,
  output logic      [35:0] rdata_out
);
  logic [35:0] mem [256];
  logic [1:0]  wait_q = 2'h0;
  logic [35:0] last_q = 36'h0;
  assign ack_out = req_in && !hold_in && (wait_q == lat_in);
  // bus off: inverse of the last word, so a late sample cannot pass by luck
  assign rdata_out = ack_out ? mem[addr_in[7:0]] : ~last_q;
  always @(posedge core_clk_in) begin
    wait_q <= (req_in && !ack_out) ? wait_q + 2'h1 : 2'h0;
    last_q <= rdata_out;
    if (ack_out && we_in) begin
      mem[addr_in[7:0]] <= wdata_in;
    end
  end
endmodule

// file: verification/tb_cpu_instruction_sequencing.sv
// Purpose: runs a short program with prompt and slow storage
// Assumes: storage model answers reads from its array
// Notes:   acks stop after a set number of references so the counters settle
`timescale 1ns/10ps
`include "cpu_seq_regs.svh"
module tb_cpu_instruction_sequencing;
  import cpu_seq_pkg::*;
  logic        core_clk_in, srst_in, mem_req, mem_we, mem_ext, mem_ack;
  logic        io_req, char_req, guard, hold;
  logic [17:0] mem_addr;
  logic [35:0] wdata, rdata, io_cmd, ref_prim, ref_ext, io_w;
  logic [11:0] char_idx, ch_w;
  logic [1:0]  lat;
  logic [17:0] seen_q [$];
  int          bad_count, checked, io_n, lim;
  cpu_instruction_sequencing dut_u (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_ext_out(mem_ext),
    .mem_addr_out(mem_addr), .mem_wdata_out(wdata), .mem_ack_in(mem_ack),
    .mem_rdata_in(rdata), .io_req_out(io_req), .io_cmd_out(io_cmd),
    .char_req_out(char_req), .char_index_out(char_idx), .guard_mode_out(guard),
    .ref_prim_out(ref_prim), .ref_ext_out(ref_ext));
  storage_model sm_u (.core_clk_in(core_clk_in), .req_in(mem_req), .we_in(mem_we),
    .addr_in(mem_addr), .wdata_in(wdata), .lat_in(lat), .hold_in(hold),
    .ack_out(mem_ack), .rdata_out(rdata));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [35:0] ins(logic [5:0] op, logic [3:0] x, logic [17:0] u);
    return {op, 4'h0, 4'h0, x, u};
  endfunction
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("counts: checked %0d mismatched %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // records each accepted storage reference and the issue pulses
  always @(posedge core_clk_in) begin
    if (mem_req && mem_ack && !srst_in) begin
      seen_q.push_back(mem_addr);
      if (seen_q.size() == lim) hold <= 1'b1;
    end
    if (io_req === 1'b1) begin
      io_n++;
      io_w = io_cmd;
    end
    if (char_req === 1'b1) ch_w = char_idx;
  end
  task automatic run_prog(input logic [1:0] l, input int n);
    logic [17:0] exp_a [22] = '{18'h0, 18'h10, 18'h2, 18'h20011, 18'h3, 18'h4, 18'h5, 18'hA1,
      18'hA2, 18'h12, 18'hA3, 18'hB0, 18'hB1, 18'hB2, 18'hB3, 18'hB4, 18'h14, 18'hB5, 18'hF0,
      18'h13, 18'hF1, 18'hA3};
    @(posedge core_clk_in);
    #1 lat = l;
    lim = n;
    hold = 1'b1;
    srst_in = 1'b1;
    seen_q.delete();
    io_n = 0;
    io_w = 36'h0;
    ch_w = 12'h0;
    repeat (4) @(posedge core_clk_in);
    check("count after reset", 36'h0, ref_prim);
    #1 srst_in = 1'b0;
    hold = 1'b0;
    check("first request", 36'h1, {35'h0, mem_req});
    for (int n = 0; n < 300 && !hold; n++) @(posedge core_clk_in);
    if (!hold) begin
      bad_count++;
      $display("mismatch reference wait expected %0d seen %0d", n, seen_q.size());
      complete_run();
    end
    repeat (3) @(posedge core_clk_in);
    for (int i = 0; i < n; i++) check("reference address", {18'h0, exp_a[i]}, {18'h0, seen_q[i]});
    check("primary count", 36'(n - 1), ref_prim);
    check("extended count", 36'h1, ref_ext);
    check("io issues", 36'h1, io_n);
    check("io word", ins(6'h30, 4'h0, 18'h77), io_w);
    check("char index", 36'h543, {24'h0, ch_w});
    check("guard", 36'h0, {35'h0, guard});
  endtask
  // tz skip, tz no skip on extended word, io, char, invalid opcode trap
  task automatic scen_prompt();
    run_prog(2'h0, 8);
    $display("test prompt storage done");
  endtask
  task automatic scen_slow();
    run_prog(2'h2, 8);
    $display("test slow storage done");
  endtask
  // then lsc, jgd taken and not, circular and algebraic shift, jp, xor to A+1, jnz,
  // execute of a nop and executive return, each seen through the fetch addresses
  task automatic scen_ops();
    run_prog(2'h1, 22);
    $display("test instruction classes done");
  endtask
  initial begin
    srst_in = 1'b1;
    hold = 1'b1;
    lat = 2'h0;
    sm_u.mem[8'h00] = ins(`OP_TZ, 4'h0, 18'h10);
    sm_u.mem[8'h02] = ins(`OP_TZ, 4'h0, 18'h20011);
    sm_u.mem[8'h03] = ins(6'h30, 4'h0, 18'h77);
    sm_u.mem[8'h04] = ins(`OP_CHAR, 4'h3, 18'h0);
    sm_u.mem[8'h05] = ins(6'h3F, 4'h0, 18'h0);
    sm_u.mem[8'h10] = 36'h0;
    sm_u.mem[8'h11] = 36'h5;
    sm_u.mem[8'hA1] = ins(`OP_NOP, 4'h0, 18'h0);
    sm_u.mem[8'h12] = 36'h200000000;
    sm_u.mem[8'h13] = ins(`OP_NOP, 4'h0, 18'h0);
    sm_u.mem[8'h14] = 36'h0;
    sm_u.mem[8'hA2] = ins(`OP_LSC, 4'h0, 18'h12);
    sm_u.mem[8'hA3] = {`OP_JGD, 8'h0D, 4'h0, 18'hB0};
    sm_u.mem[8'hB0] = {`OP_JGD, 8'h0D, 4'h0, 18'hC0};
    sm_u.mem[8'hB1] = {`OP_SHC, 8'h20, 4'h0, 18'h1};
    sm_u.mem[8'hB2] = ins(`OP_SHA, 4'h0, 18'h1);
    sm_u.mem[8'hB3] = ins(`OP_JP, 4'h0, 18'hD0);
    sm_u.mem[8'hB4] = ins(`OP_XOR, 4'h0, 18'h14);
    sm_u.mem[8'hB5] = {`OP_JNZ, 8'h01, 4'h0, 18'hF0};
    sm_u.mem[8'hF0] = ins(`OP_EX, 4'h0, 18'h13);
    sm_u.mem[8'hF1] = ins(`OP_ER, 4'h0, 18'h0);
    scen_prompt();
    scen_slow();
    scen_ops();
    complete_run();
  end
endmodule
